/* File: rtl/pdt_trigger.sv */
// Notes on behaviour
// R1 - Shorter mode: fire on pattern false edge if true time was below limit.
// R2 - Shorter mode: event held past limit is dropped; search restarts next pattern.
// R3 - Single duration limit accepted from 20 ns to 160 ms, 10 ns resolution.
// R4 - Count one needs duration; later counted events of any width add one.
// R5 - Range mode: fire on false edge when true time strictly between limits.
// R6 - Range mode: outside window restarts search; in-window false edge triggers.
// R7 - Range minimum 20 ns to 160 ms; maximum at least 10 ns above minimum.
// R8 - Counted event needs all used inputs matching; fire after programmed count.
// R9 - Event count accepts 1 to 32000, resets to one.
// R10 - Longer mode: fire on false edge after true longer than limit; early restarts.
// R11 - Entered (default) fires on pattern true edge; exited on false edge.
// R12 - Inputs compared to high, low or don't-care; all used must match.
// R13 - Timer counts 10 ns ticks, loads one at pattern start, saturates past maximum.
`timescale 1ns/10ps
module pdt_trigger #(
   parameter int N_CH = pdt_pkg::DEF_CHANNELS
) (
   // Clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            reset_n,
   // Sampled channels
   input  wire logic [N_CH-1:0]                 chan_in,
   // Configuration; all but pat_sel captured at arm, pat_sel compared live
   input  wire logic [2*N_CH-1:0]               pat_sel,
   input  wire logic [2:0]                      mode_sel,
   input  wire logic [pdt_pkg::LIMIT_W-1:0]     dur_lo,
   input  wire logic [pdt_pkg::LIMIT_W-1:0]     dur_hi,
   input  wire logic [pdt_pkg::COUNT_W-1:0]     evt_target,
   // Control
   input  wire logic                            arm,
   input  wire logic                            disarm,
   // Status and trigger
   output logic                                 trig_out,
   output logic                                 armed,
   output logic                                 pattern_true,
   output logic [pdt_pkg::COUNT_W-1:0]          event_count,
   output logic                                 cfg_err
);

   typedef struct packed {
      pdt_pkg::pdt_state_t         state;
      pdt_pkg::pdt_mode_t          mode;
      logic [pdt_pkg::LIMIT_W-1:0] lo;
      logic [pdt_pkg::LIMIT_W-1:0] hi;
      logic [pdt_pkg::COUNT_W-1:0] target;
      logic [pdt_pkg::COUNT_W-1:0] cnt;
      logic                        pat;
      logic                        seen;
      logic                        trig;
      logic                        armed;
      logic                        cfg_err;
   } pdt_regs_t;

   pdt_regs_t                   regs_ff;
   pdt_regs_t                   nxt_regs;
   logic [N_CH-1:0]             match;
   logic                        pat_now;
   logic                        rise;
   logic                        fall;
   logic [pdt_pkg::LIMIT_W-1:0] dur;

   if (N_CH < 1) begin : g_bad_ch
      $error("pdt_trigger: need at least one channel");
   end
   if (pdt_pkg::TICK_CYCLES != 1) begin : g_bad_tick
      $error("pdt_trigger: timer assumes one tick per clock");
   end

   // Per-input compare; reserved select code acts as don't-care
   for (genvar i = 0; i < N_CH; i++) begin : g_match
      always_comb begin
         case (pat_sel[2*i +: 2])
            pdt_pkg::SEL_HIGH: match[i] = chan_in[i];  // R12
            pdt_pkg::SEL_LOW:  match[i] = ~chan_in[i]; // R12
            default:           match[i] = 1'b1;
         endcase
      end
   end

   assign pat_now = &match; // R12 R8
   assign rise    = pat_now & ~regs_ff.pat;
   assign fall    = ~pat_now & regs_ff.pat;

   pdt_timer #(
      .W   (pdt_pkg::LIMIT_W),
      .SAT (pdt_pkg::TIMER_SAT)
   ) u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pat_rise (rise),
      .pat_true (pat_now),
      .dur_ff   (dur)
   );

   always_comb begin
      logic [pdt_pkg::LIMIT_W-1:0] lo_c;
      logic [pdt_pkg::LIMIT_W-1:0] hi_c;
      logic [pdt_pkg::COUNT_W-1:0] tgt_c;
      logic                        err_c;
      logic                        event_hit;
      logic                        dur_ok;
      logic [pdt_pkg::COUNT_W-1:0] cnt_inc;

      lo_c      = dur_lo;
      hi_c      = dur_hi;
      tgt_c     = evt_target;
      err_c     = 1'b0;
      event_hit = 1'b0;
      dur_ok    = 1'b0;
      cnt_inc   = regs_ff.cnt + 15'h0001;
      nxt_regs  = regs_ff;
      nxt_regs.pat  = pat_now;
      nxt_regs.trig = 1'b0;

      // Out-of-range settings are clamped and flagged, never refused
      if (lo_c < pdt_pkg::LIMIT_MIN_TICKS) begin
         lo_c  = pdt_pkg::LIMIT_MIN_TICKS; // R3 R7
         err_c = 1'b1;
      end else if (lo_c > pdt_pkg::LIMIT_MAX_TICKS) begin
         lo_c  = pdt_pkg::LIMIT_MAX_TICKS; // R3 R7
         err_c = 1'b1;
      end
      if ((mode_sel == pdt_pkg::MODE_RANGE) && (hi_c < lo_c + pdt_pkg::RANGE_GAP_TICKS)) begin
         hi_c  = lo_c + pdt_pkg::RANGE_GAP_TICKS; // R7
         err_c = 1'b1;
      end
      if (tgt_c == '0) begin
         tgt_c = pdt_pkg::COUNT_RESET; // R9
         err_c = 1'b1;
      end else if (tgt_c > pdt_pkg::COUNT_MAX) begin
         tgt_c = pdt_pkg::COUNT_MAX; // R9
         err_c = 1'b1;
      end

      // Qualification of the just-ended true interval
      case (regs_ff.mode)
         pdt_pkg::MODE_SHORTER: dur_ok = dur < regs_ff.lo;                     // R1 R2
         pdt_pkg::MODE_LONGER:  dur_ok = dur > regs_ff.lo;                     // R10
         pdt_pkg::MODE_RANGE:   dur_ok = (dur > regs_ff.lo) && (dur < regs_ff.hi); // R5 R6
         default:               dur_ok = 1'b1;
      endcase

      // Entered counts true edges; every other mode counts false edges
      if (regs_ff.mode == pdt_pkg::MODE_ENTERED) begin
         event_hit = rise; // R11
      end else begin
         event_hit = fall & regs_ff.seen; // R11 R1 R5 R10
      end

      // A false edge only counts if its true edge was seen while armed
      if (rise) begin
         nxt_regs.seen = 1'b1;
      end

      case (regs_ff.state)
         pdt_pkg::ST_IDLE: begin
            if (arm) begin
               nxt_regs.state   = pdt_pkg::ST_SEARCH;
               nxt_regs.mode    = pdt_pkg::pdt_mode_t'(mode_sel);
               nxt_regs.lo      = lo_c;
               nxt_regs.hi      = hi_c;
               nxt_regs.target  = tgt_c;
               nxt_regs.cnt     = '0;
               nxt_regs.seen    = 1'b0;
               nxt_regs.cfg_err = err_c;
            end
         end
         pdt_pkg::ST_SEARCH: begin
            // First event must meet duration; failures simply wait for next
            if (event_hit && dur_ok) begin
               nxt_regs.cnt = 15'h0001; // R4 R2 R6
               if (regs_ff.target == 15'h0001) begin
                  nxt_regs.trig  = 1'b1; // R4
                  nxt_regs.state = pdt_pkg::ST_IDLE;
               end else begin
                  nxt_regs.state = pdt_pkg::ST_COUNT;
               end
            end
         end
         pdt_pkg::ST_COUNT: begin
            if (event_hit) begin
               nxt_regs.cnt = cnt_inc; // R4 R8
               if (cnt_inc == regs_ff.target) begin
                  nxt_regs.trig  = 1'b1; // R8
                  nxt_regs.state = pdt_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            nxt_regs.state = pdt_pkg::ST_IDLE;
         end
      endcase

      if (disarm) begin
         nxt_regs.state = pdt_pkg::ST_IDLE;
         nxt_regs.trig  = 1'b0;
      end

      // Own flop so the status pin carries no decode glitches
      nxt_regs.armed = (nxt_regs.state != pdt_pkg::ST_IDLE);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regs_ff.state   <= pdt_pkg::ST_IDLE;
         regs_ff.mode    <= pdt_pkg::MODE_ENTERED;   // R11
         regs_ff.lo      <= pdt_pkg::LIMIT_MIN_TICKS;
         regs_ff.hi      <= pdt_pkg::LIMIT_MIN_TICKS + pdt_pkg::RANGE_GAP_TICKS;
         regs_ff.target  <= pdt_pkg::COUNT_RESET;    // R9
         regs_ff.cnt     <= '0;
         regs_ff.pat     <= 1'b0;
         regs_ff.seen    <= 1'b0;
         regs_ff.trig    <= 1'b0;
         regs_ff.armed   <= 1'b0;
         regs_ff.cfg_err <= 1'b0;
      end else begin
         regs_ff <= nxt_regs;
      end
   end

   assign trig_out     = regs_ff.trig;
   assign armed        = regs_ff.armed;
   assign pattern_true = regs_ff.pat;
   assign event_count  = regs_ff.cnt;
   assign cfg_err      = regs_ff.cfg_err;

endmodule

/* File: rtl/pdt_pkg.sv */
package pdt_pkg;

   // Timing base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS       = 10;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

   // Duration limits, in ns and in ticks
   localparam int LIMIT_MIN_NS  = 20;
   localparam int LIMIT_MAX_NS  = 160_000_000;
   localparam int RANGE_GAP_NS  = 10;
   localparam int LIMIT_W       = 24;
   localparam logic [LIMIT_W-1:0] LIMIT_MIN_TICKS = LIMIT_W'(LIMIT_MIN_NS / TICK_NS);
   localparam logic [LIMIT_W-1:0] LIMIT_MAX_TICKS = LIMIT_W'(LIMIT_MAX_NS / TICK_NS);
   localparam logic [LIMIT_W-1:0] RANGE_GAP_TICKS = LIMIT_W'(RANGE_GAP_NS / TICK_NS);
   localparam logic [LIMIT_W-1:0] TIMER_SAT       = LIMIT_MAX_TICKS + 24'h000001;

   // Event count
   localparam int COUNT_W = 15;
   localparam logic [COUNT_W-1:0] COUNT_MAX   = 15'h7d00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 15'h0001;

   localparam int DEF_CHANNELS = 2;

   typedef enum logic [2:0] {
      MODE_ENTERED = 3'h0,
      MODE_EXITED  = 3'h1,
      MODE_SHORTER = 3'h2,
      MODE_LONGER  = 3'h3,
      MODE_RANGE   = 3'h4
   } pdt_mode_t;

   typedef enum logic [1:0] {
      SEL_DONT_CARE = 2'h0,
      SEL_HIGH      = 2'h1,
      SEL_LOW       = 2'h2
   } pdt_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_SEARCH = 2'h1,
      ST_COUNT  = 2'h2
   } pdt_state_t;

endpackage

/* File: rtl/pdt_timer.sv */
`timescale 1ns/10ps
module pdt_timer #(
   parameter int                          W   = pdt_pkg::LIMIT_W,
   parameter logic [pdt_pkg::LIMIT_W-1:0] SAT = pdt_pkg::TIMER_SAT
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // Pattern state
   input  wire logic         pat_rise,
   input  wire logic         pat_true,
   // Measured time in ticks
   output logic [W-1:0]      dur_ff
);

   logic [W-1:0] nxt_dur;

   if (W != pdt_pkg::LIMIT_W) begin : g_bad_width
      $error("pdt_timer: width must match limit width");
   end

   // Loads one on each start, saturates so overlong events stay rejected in shorter mode
   always_comb begin
      nxt_dur = dur_ff;
      if (pat_rise) begin
         nxt_dur = {{(W-1){1'b0}}, 1'b1}; // R13
      end else if (pat_true && (dur_ff < SAT)) begin
         nxt_dur = dur_ff + {{(W-1){1'b0}}, 1'b1}; // R13
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dur_ff <= '0;
      end else begin
         dur_ff <= nxt_dur;
      end
   end

endmodule

/* File: tb/pdt_sva.sv */
`timescale 1ns/10ps
module pdt_sva #(
   parameter int N_CH = pdt_pkg::DEF_CHANNELS
) (
   // Clock, reset, inputs
   input wire logic                        core_clk,
   input wire logic                        reset_n,
   input wire logic [N_CH-1:0]             chan_in,
   input wire logic [2*N_CH-1:0]           pat_sel,
   input wire logic [2:0]                  mode_sel,
   input wire logic [pdt_pkg::LIMIT_W-1:0] dur_lo,
   input wire logic [pdt_pkg::LIMIT_W-1:0] dur_hi,
   input wire logic [pdt_pkg::COUNT_W-1:0] evt_target,
   input wire logic                        arm,
   input wire logic                        disarm,
   // Outputs
   input wire logic                        trig_out,
   input wire logic                        armed,
   input wire logic                        pattern_true,
   input wire logic [pdt_pkg::COUNT_W-1:0] event_count,
   input wire logic                        cfg_err
);
   logic [pdt_pkg::LIMIT_W-1:0] run_ff;
   logic                        pat_ok;
   always_comb begin
      pat_ok = 1'b1;
      for (int i = 0; i < N_CH; i++) begin
         if (pat_sel[2*i+:2] == 2'h1 && !chan_in[i]) pat_ok = 1'b0;
         if (pat_sel[2*i+:2] == 2'h2 && chan_in[i]) pat_ok = 1'b0;
      end
   end
   // Length of the current true run, as seen on pattern_true
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         run_ff <= '0;
      end else begin
         run_ff <= pattern_true ? run_ff + 24'h000001 : 24'h000000;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_trig_pulse: assert property (trig_out |=> !trig_out)
      else $error("trig_out wider than one cycle");
   a_trig_armed: assert property (trig_out |-> $past(armed) && !armed)
      else $error("trig_out without armed search");
   a_arm_starts: assert property (!armed && arm && !disarm |=> armed)
      else $error("arm did not start a search");
   a_disarm_idles: assert property (disarm |=> !armed && !trig_out)
      else $error("disarm did not idle");
   a_pat_compare: assert property ($past(armed) && armed |-> pattern_true == $past(pat_ok))
      else $error("pattern compare wrong");
   a_entered_edge: assert property (trig_out && mode_sel == 3'h0 |->
      pattern_true && !$past(pattern_true)) else $error("entered not on true edge");
   a_false_edge: assert property (trig_out && mode_sel != 3'h0 |->
      !pattern_true && $past(pattern_true)) else $error("fire not on false edge");
   a_count_target: assert property (trig_out && evt_target != 0 && evt_target <=
      pdt_pkg::COUNT_MAX |-> event_count == evt_target) else $error("count at fire");
   a_short_qual: assert property (trig_out && mode_sel == 3'h2 && evt_target == 1 |->
      run_ff < dur_lo) else $error("shorter fired too long");
   a_long_qual: assert property (trig_out && mode_sel == 3'h3 && evt_target == 1 |->
      run_ff > dur_lo) else $error("longer fired too short");
   a_range_qual: assert property (trig_out && mode_sel == 3'h4 && evt_target == 1 |->
      run_ff > dur_lo && run_ff < dur_hi) else $error("range fired outside");
   c_short_fire: cover property (trig_out && mode_sel == 3'h2);
   c_range_fire: cover property (trig_out && mode_sel == 3'h4);
   c_clamped: cover property ($rose(cfg_err));
endmodule
bind pdt_trigger pdt_sva #(.N_CH(N_CH)) pdt_sva_inst (
   .core_clk(core_clk), .reset_n(reset_n), .chan_in(chan_in), .pat_sel(pat_sel),
   .mode_sel(mode_sel), .dur_lo(dur_lo), .dur_hi(dur_hi), .evt_target(evt_target),
   .arm(arm), .disarm(disarm), .trig_out(trig_out), .armed(armed),
   .pattern_true(pattern_true), .event_count(event_count), .cfg_err(cfg_err));

/* File: tb/pdt_chan_model.sv */
`timescale 1ns/10ps
module pdt_chan_model (
   // Sample clock
   input wire logic core_clk,
   // Channels to the trigger
   output logic [1:0] chan
);
   logic pulse_ch  = 1'b0;
   logic toggle_ch = 1'b0;
   // One writer per channel bit
   assign chan = {toggle_ch, pulse_ch};
   // Channel 1 toggles so a don't-care input is seen to be ignored
   always @(negedge core_clk) toggle_ch <= ~toggle_ch;
   // Pulse of n samples on channel 0, then a quiet gap
   task automatic pulse(input int n);
      @(negedge core_clk);
      pulse_ch = 1'b1;
      repeat (n) @(negedge core_clk);
      pulse_ch = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic                        core_clk = 1'b0;
   logic                        reset_n, arm, disarm;
   logic [1:0]                  chan_in;
   logic [3:0]                  pat_sel;
   logic [2:0]                  mode_sel;
   logic [pdt_pkg::LIMIT_W-1:0] dur_lo, dur_hi;
   logic [pdt_pkg::COUNT_W-1:0] evt_target, event_count;
   logic                        trig_out, armed, pattern_true, cfg_err;
   int                          mismatches = 0, n_compared = 0, cycles = 0, fired_at;
   int                          trig_seen = 0, base;
   localparam int W[6] = '{20, 8, 15, 5, 7, 2};
   // Mode, lo, hi, target, pulse that fires (0 none), count, clamp flag
   localparam int T[12][7] = '{
      '{0, 2, 3, 1, 1, 1, 0}, '{0, 2, 3, 0, 1, 1, 1},
      '{1, 2, 3, 2, 2, 2, 0}, '{2, 10, 11, 1, 2, 1, 0},
      '{2, 10, 11, 3, 4, 3, 0}, '{2, 8, 9, 1, 4, 1, 0},
      '{3, 10, 11, 3, 3, 3, 0}, '{3, 20, 21, 1, 0, 0, 0},
      '{4, 6, 10, 3, 4, 3, 0}, '{4, 5, 8, 1, 5, 1, 0},
      '{3, 1, 2, 1, 1, 1, 1}, '{4, 6, 6, 1, 0, 0, 1}};
   always #5 core_clk = ~core_clk;
   pdt_chan_model pdt_chan_model_inst (.core_clk(core_clk), .chan(chan_in));
   pdt_trigger #(.N_CH(2)) pdt_trigger_inst (
      .core_clk(core_clk), .reset_n(reset_n), .chan_in(chan_in), .pat_sel(pat_sel),
      .mode_sel(mode_sel), .dur_lo(dur_lo), .dur_hi(dur_hi), .evt_target(evt_target),
      .arm(arm), .disarm(disarm), .trig_out(trig_out), .armed(armed),
      .pattern_true(pattern_true), .event_count(event_count), .cfg_err(cfg_err));
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, well above the roughly 1100 cycles the table needs
   // Sampled mid-cycle, where the trigger pulse has settled
   always @(negedge core_clk) begin
      cycles++;
      if (trig_out === 1'b1) trig_seen++;
      if (cycles > 4000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      {reset_n, arm, disarm} = 3'h0;
      pat_sel = 4'h1;
      {mode_sel, dur_lo, dur_hi, evt_target} = '0;
      repeat (16) @(negedge core_clk);
      reset_n = 1'b1;
      chk("reset outputs", 24'h0, 24'({trig_out, armed, pattern_true, event_count, cfg_err}));
      for (int r = 0; r < 12; r++) begin
         mode_sel = 3'(T[r][0]);
         pat_sel = (r == 0) ? 4'h2 : 4'h1;
         dur_lo = 24'(T[r][1]);
         dur_hi = 24'(T[r][2]);
         evt_target = 15'(T[r][3]);
         arm = 1'b1;
         @(negedge core_clk);
         arm = 1'b0;
         base = trig_seen;
         fired_at = 0;
         for (int p = 0; p < 6; p++) begin
            pdt_chan_model_inst.pulse(W[p]);
            if (trig_seen != base && fired_at == 0) fired_at = p + 1;
         end
         chk("fired pulse", 24'(T[r][4]), 24'(fired_at));
         chk("trigger count", 24'(T[r][4] != 0), 24'(trig_seen - base));
         chk("event_count", 24'(T[r][5]), 24'(event_count));
         chk("cfg_err", 24'(T[r][6]), 24'(cfg_err));
         chk("armed", 24'(T[r][4] == 0), 24'(armed));
         disarm = 1'b1;
         @(negedge core_clk);
         disarm = 1'b0;
         $display("test %0d done", r);
      end
      give_verdict();
   end
endmodule
